// ---- logic/dctc_timer.sv ----
// Purpose: two counter/timers with mode, gating and clock selection, plus rate enables
//          for the two timers that live elsewhere
// Assumes: byte register bus on clk; polarity and external clock choice inputs are
//          registers on clk; count pins and interrupt lines are asynchronous
// Notes:   read data is registered and appears one cycle after the read strobe
`timescale 1ns/1ps
module dctc_timer
  import dctc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer_zero_count_pin,
  input  wire logic       timer_one_count_pin,
  input  wire logic       ext_irq_zero_line,
  input  wire logic       ext_irq_one_line,
  input  wire logic       ext_irq_zero_polarity,
  input  wire logic       ext_irq_one_polarity,
  input  wire logic       ext_clock_pin,
  input  wire logic       timer_two_extclk_choice,
  input  wire logic       timer_three_extclk_choice,
  input  wire logic       zero_vector_ack,
  input  wire logic       one_vector_ack,
  output logic            timer_zero_overflow_flag,
  output logic            timer_one_overflow_flag,
  output logic            timer_one_overflow_tick,
  output logic            timer_two_low_tick,
  output logic            timer_two_high_tick,
  output logic            timer_three_low_tick,
  output logic            timer_three_high_tick
);

  dctc_tick_if ticks ();

  logic [7:0]  timer_mode_select;
  logic [7:0]  timer_clock_select;
  logic [7:0]  timer_zero_count_low;
  logic [7:0]  timer_zero_count_high;
  logic [7:0]  timer_one_count_low;
  logic [7:0]  timer_one_count_high;
  logic        timer_zero_run;
  logic        timer_one_run;
  logic [3:0]  pin_meta;
  logic [3:0]  pin_sync;
  logic [3:0]  pin_prev;
  logic [7:0]  read_mux;
  logic [7:0]  next_zero_low;
  logic [7:0]  next_zero_high;
  logic [7:0]  next_one_low;
  logic [7:0]  next_one_high;
  logic        next_zero_flag;
  logic        next_one_flag;

  dctc_prescaler u_prescaler (
    .clk           (clk),
    .nrst          (nrst),
    .ext_clock_pin (ext_clock_pin),
    .ticks         (ticks.source)
  );

  // 13, 16, reload or split-low step; result is {carry, high, low}
  function automatic logic [16:0] dctc_step(input logic [1:0] mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi,
                                            input logic       inc);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [16:0] res;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    res = {1'b0, hi, lo};
    if (inc)
    begin
      case (mode)
        // upper three low bits are left as they are
        MODE_13BIT:  res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        MODE_16BIT:  res = s16;
        MODE_RELOAD: res = {s8[8], hi, s8[8] ? hi : s8[7:0]};
        default:     res = {s8[8], hi, s8[7:0]};
      endcase
    end
    return res;
  endfunction

  // address match, shared by the write strobes
  function automatic logic dctc_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // pins and irq lines: two flops, then a third for the falling edge
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    wire pin_in = (i == 0) ? timer_zero_count_pin :
                  (i == 1) ? timer_one_count_pin :
                  (i == 2) ? ext_irq_zero_line : ext_irq_one_line;
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
        pin_prev[i] <= 1'b0;
      end
      else
      begin
        pin_meta[i] <= pin_in;
        pin_sync[i] <= pin_meta[i];
        pin_prev[i] <= pin_sync[i];
      end
    end
  end

  // write strobes
  wire wr_flag = sfr_wr & dctc_hit(sfr_addr, ADDR_RUN_FLAG);
  wire wr_mode = sfr_wr & dctc_hit(sfr_addr, ADDR_MODE);
  wire wr_zl   = sfr_wr & dctc_hit(sfr_addr, ADDR_ZERO_LOW);
  wire wr_ol   = sfr_wr & dctc_hit(sfr_addr, ADDR_ONE_LOW);
  wire wr_zh   = sfr_wr & dctc_hit(sfr_addr, ADDR_ZERO_HIGH);
  wire wr_oh   = sfr_wr & dctc_hit(sfr_addr, ADDR_ONE_HIGH);
  wire wr_clk  = sfr_wr & dctc_hit(sfr_addr, ADDR_CLOCK_SEL);

  // field views
  wire [1:0] zero_mode  = timer_mode_select[MODE_ZERO_HI:MODE_ZERO_LO];
  wire [1:0] one_mode   = timer_mode_select[MODE_ONE_HI:MODE_ONE_LO];
  wire       zero_gate  = timer_mode_select[MODE_ZERO_GATE];
  wire       one_gate   = timer_mode_select[MODE_ONE_GATE];
  wire       zero_ct    = timer_mode_select[MODE_ZERO_CT];
  wire       one_ct     = timer_mode_select[MODE_ONE_CT];
  wire [1:0] scale      = timer_clock_select[CLK_SCALE_HI:CLK_SCALE_LO];
  wire       zero_split = (zero_mode == MODE_SPLIT);

  // falling edges on the count pins; polarity bit 1 means active high
  wire zero_fall   = pin_prev[0] & ~pin_sync[0];
  wire one_fall    = pin_prev[1] & ~pin_sync[1];
  wire zero_irq_on = (pin_sync[2] == ext_irq_zero_polarity);
  wire one_irq_on  = (pin_sync[3] == ext_irq_one_polarity);

  // shared prescaled rate; external / 8 comes in already synchronised
  wire presc_tick = (scale == SCALE_DIV12) ? ticks.div12 :
                    (scale == SCALE_DIV4)  ? ticks.div4 :
                    (scale == SCALE_DIV48) ? ticks.div48 : ticks.ext_div8;

  // timer function clocks: sysclk when the select bit is 1, else prescaled
  wire zero_timer_clk = timer_clock_select[CLK_ZERO_SYS] ? 1'b1 : presc_tick;
  wire one_timer_clk  = timer_clock_select[CLK_ONE_SYS] ? 1'b1 : presc_tick;

  // timer zero: gating, clock source, and the split high byte
  wire zero_enable = timer_zero_run & (~zero_gate | zero_irq_on);
  wire zero_clk    = zero_ct ? zero_fall : zero_timer_clk;
  wire zero_inc    = zero_enable & zero_clk;
  wire high_inc    = zero_split & timer_one_run & zero_timer_clk;

  // timer one: in split mode it cannot count pins and runs unless its own mode is 3
  wire one_gated   = timer_one_run & (~one_gate | one_irq_on);
  wire one_enable  = zero_split ? 1'b1 : one_gated;
  wire one_clk     = (one_ct & ~zero_split) ? one_fall : one_timer_clk;
  wire one_inc     = one_enable & one_clk & (one_mode != MODE_SPLIT);

  wire [16:0] zero_step = dctc_step(zero_mode, timer_zero_count_low,
                                    timer_zero_count_high, zero_inc);
  wire [16:0] one_step  = dctc_step(one_mode, timer_one_count_low,
                                    timer_one_count_high, one_inc);
  wire [8:0]  high_sum  = {1'b0, timer_zero_count_high} + 9'h001;

  wire zero_ovf = zero_step[16];
  wire high_ovf = high_inc & high_sum[8];
  wire one_ovf  = one_step[16];
  // in split mode the high byte owns the timer one flag
  wire one_flag_set = zero_split ? high_ovf : one_ovf;

  // a write beats the increment in the same cycle
  assign next_zero_low  = wr_zl ? sfr_wdata : zero_step[7:0];
  assign next_zero_high = wr_zh ? sfr_wdata :
                          zero_split ? (high_inc ? high_sum[7:0] : timer_zero_count_high) :
                          zero_step[15:8];
  assign next_one_low   = wr_ol ? sfr_wdata : one_step[7:0];
  assign next_one_high  = wr_oh ? sfr_wdata : one_step[15:8];

  // hardware set wins over a software or vector clear in the same cycle
  assign next_zero_flag = zero_ovf | (wr_flag ? sfr_wdata[RUN_ZERO_FLAG] :
                          (timer_zero_overflow_flag & ~zero_vector_ack));
  assign next_one_flag  = one_flag_set | (wr_flag ? sfr_wdata[RUN_ONE_FLAG] :
                          (timer_one_overflow_flag & ~one_vector_ack));

  // count registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_zero_count_low  <= RESET_BYTE;
      timer_zero_count_high <= RESET_BYTE;
      timer_one_count_low   <= RESET_BYTE;
      timer_one_count_high  <= RESET_BYTE;
    end
    else
    begin
      timer_zero_count_low  <= next_zero_low;
      timer_zero_count_high <= next_zero_high;
      timer_one_count_low   <= next_one_low;
      timer_one_count_high  <= next_one_high;
    end
  end

  // configuration, run bits and flags; run does not clear the count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_mode_select        <= RESET_BYTE;
      timer_clock_select       <= RESET_BYTE;
      timer_zero_run           <= 1'b0;
      timer_one_run            <= 1'b0;
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag  <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_select <= sfr_wdata;
      if (wr_clk)
        timer_clock_select <= sfr_wdata;
      if (wr_flag)
      begin
        timer_zero_run <= sfr_wdata[RUN_ZERO_RUN];
        timer_one_run  <= sfr_wdata[RUN_ONE_RUN];
      end
      timer_zero_overflow_flag <= next_zero_flag;
      timer_one_overflow_flag  <= next_one_flag;
    end
  end

  // read decode; the low nibble of the run/flag byte belongs to the irq logic
  always_comb
  begin
    read_mux = RESET_BYTE;
    if (sfr_addr == ADDR_RUN_FLAG)
      read_mux = {timer_one_overflow_flag, timer_one_run,
                  timer_zero_overflow_flag, timer_zero_run, 4'h0};
    else if (sfr_addr == ADDR_MODE)
      read_mux = timer_mode_select;
    else if (sfr_addr == ADDR_ZERO_LOW)
      read_mux = timer_zero_count_low;
    else if (sfr_addr == ADDR_ONE_LOW)
      read_mux = timer_one_count_low;
    else if (sfr_addr == ADDR_ZERO_HIGH)
      read_mux = timer_zero_count_high;
    else if (sfr_addr == ADDR_ONE_HIGH)
      read_mux = timer_one_count_high;
    else if (sfr_addr == ADDR_CLOCK_SEL)
      read_mux = timer_clock_select;
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sfr_rdata <= RESET_BYTE;
    else if (sfr_rd)
      sfr_rdata <= read_mux;
  end

  // rate enables for the two outside timers; their split decision is made there
  wire two_ext   = timer_two_extclk_choice ? ticks.ext_div8 : ticks.div12;
  wire three_ext = timer_three_extclk_choice ? ticks.ext_div8 : ticks.div12;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_two_low_tick      <= 1'b0;
      timer_two_high_tick     <= 1'b0;
      timer_three_low_tick    <= 1'b0;
      timer_three_high_tick   <= 1'b0;
      timer_one_overflow_tick <= 1'b0;
    end
    else
    begin
      timer_two_low_tick      <= timer_clock_select[CLK_TWO_LOW] | two_ext;
      timer_two_high_tick     <= timer_clock_select[CLK_TWO_HIGH] | two_ext;
      timer_three_low_tick    <= timer_clock_select[CLK_THREE_LOW] | three_ext;
      timer_three_high_tick   <= timer_clock_select[CLK_THREE_HIGH] | three_ext;
      timer_one_overflow_tick <= one_ovf; // still runs baud rates in split mode
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  wire zero_quiet = !wr_zl && !wr_zh;
  wire one_quiet  = !wr_ol && !wr_oh;

  sequence s_zero_wraps_13;
    zero_mode == MODE_13BIT && zero_inc && timer_zero_count_high == 8'hFF &&
    timer_zero_count_low[4:0] == 5'h1F && zero_quiet && !wr_flag;
  endsequence

  sequence s_zero_cleared_13;
    timer_zero_count_high == 8'h00 && timer_zero_count_low[4:0] == 5'h00 &&
    timer_zero_overflow_flag;
  endsequence

  a_gate_blocks_zero : assert property (
    zero_gate && !zero_irq_on && !zero_split && zero_quiet |=>
      $stable({timer_zero_count_high, timer_zero_count_low}))
    else $error("gated timer zero moved with irq line inactive");

  a_ungated_one_runs : assert property (
    timer_one_run && !one_gate && !one_ct && timer_clock_select[CLK_ONE_SYS] &&
    one_mode == MODE_16BIT && !zero_split && one_quiet |=>
      {timer_one_count_high, timer_one_count_low} ==
      16'($past({timer_one_count_high, timer_one_count_low}) + 16'h0001))
    else $error("ungated timer one did not count on sysclk");

  a_gated_one_holds : assert property (
    one_gate && !one_irq_on && !zero_split && one_quiet |=>
      $stable({timer_one_count_high, timer_one_count_low}))
    else $error("gated timer one moved with irq line inactive");

  a_pin_count_idle : assert property (
    one_ct && !zero_split && !one_fall && one_quiet |=>
      $stable({timer_one_count_high, timer_one_count_low}))
    else $error("timer one counted without a pin edge");

  a_one_per_edge : assert property (
    zero_ct && zero_enable && zero_fall && zero_mode == MODE_16BIT && zero_quiet |=>
      {timer_zero_count_high, timer_zero_count_low} ==
      16'($past({timer_zero_count_high, timer_zero_count_low}) + 16'h0001))
    else $error("pin edge did not add exactly one");

  a_one_inactive : assert property (
    one_mode == MODE_SPLIT && one_quiet |=>
      $stable({timer_one_count_high, timer_one_count_low}))
    else $error("timer one counted while inactive");

  a_thirteen_wrap : assert property (
    s_zero_wraps_13 |=> s_zero_cleared_13)
    else $error("13-bit wrap did not clear and flag");

  a_reload_from_high : assert property (
    zero_mode == MODE_RELOAD && zero_inc && timer_zero_count_low == 8'hFF && zero_quiet |=>
      timer_zero_count_low == $past(timer_zero_count_high) && timer_zero_overflow_flag)
    else $error("reload mode did not reload from high byte");

  a_split_high_flag : assert property (
    high_inc && timer_zero_count_high == 8'hFF && !wr_zh |=> timer_one_overflow_flag)
    else $error("split high byte wrap did not set timer one flag");

  a_write_beats_inc : assert property (
    wr_zl && zero_inc |=> timer_zero_count_low == $past(sfr_wdata))
    else $error("count write lost to increment");

  a_sysclk_select : assert property (
    !zero_ct && timer_clock_select[CLK_ZERO_SYS] && zero_enable && zero_mode == MODE_16BIT &&
    zero_quiet |=> !$stable({timer_zero_count_high, timer_zero_count_low}))
    else $error("timer zero ignored sysclk select");

  a_three_low_sys : assert property (
    timer_clock_select[CLK_THREE_LOW] |=> timer_three_low_tick [*1])
    else $error("timer three low tick missing with sysclk select");

endmodule

// ---- logic/dctc_pkg.sv ----
// Purpose: shared constants for the dual counter/timer and clock select block
// Assumes: byte-wide special function register bus on the system clock
// Notes:   bit positions are ints, field codes are sized to their fields
package dctc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_RUN_FLAG   = 8'h88;
  localparam logic [7:0] ADDR_MODE       = 8'h89;
  localparam logic [7:0] ADDR_ZERO_LOW   = 8'h8A;
  localparam logic [7:0] ADDR_ONE_LOW    = 8'h8B;
  localparam logic [7:0] ADDR_ZERO_HIGH  = 8'h8C;
  localparam logic [7:0] ADDR_ONE_HIGH   = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_SEL  = 8'h8E;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // timer_mode_select fields
  localparam int MODE_ONE_GATE   = 7;
  localparam int MODE_ONE_CT     = 6;
  localparam int MODE_ONE_HI     = 5;
  localparam int MODE_ONE_LO     = 4;
  localparam int MODE_ZERO_GATE  = 3;
  localparam int MODE_ZERO_CT    = 2;
  localparam int MODE_ZERO_HI    = 1;
  localparam int MODE_ZERO_LO    = 0;

  // timer_clock_select fields
  localparam int CLK_THREE_HIGH  = 7;
  localparam int CLK_THREE_LOW   = 6;
  localparam int CLK_TWO_HIGH    = 5;
  localparam int CLK_TWO_LOW     = 4;
  localparam int CLK_ONE_SYS     = 3;
  localparam int CLK_ZERO_SYS    = 2;
  localparam int CLK_SCALE_HI    = 1;
  localparam int CLK_SCALE_LO    = 0;

  // timer_run_flag_register fields
  localparam int RUN_ONE_FLAG    = 7;
  localparam int RUN_ONE_RUN     = 6;
  localparam int RUN_ZERO_FLAG   = 5;
  localparam int RUN_ZERO_RUN    = 4;

  // mode field codes
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // prescale field codes
  localparam logic [1:0] SCALE_DIV12 = 2'h0;
  localparam logic [1:0] SCALE_DIV4  = 2'h1;
  localparam logic [1:0] SCALE_DIV48 = 2'h2;
  localparam logic [1:0] SCALE_EXT8  = 2'h3;

  // divider ratios
  localparam int unsigned DIV_SHORT  = 4;
  localparam int unsigned DIV_MID    = 12;
  localparam int unsigned DIV_LONG   = 48;
  localparam int unsigned DIV_EXT    = 8;
  localparam int          DIV_WIDTH  = 6;
  localparam int          EXT_WIDTH  = 3;

endpackage

// ---- logic/dctc_tick_if.sv ----
// Purpose: carries the one-cycle rate enables from the prescaler to the timers
// Assumes: every enable is a single system clock pulse
// Notes:   the external rate is already in the system clock domain
`timescale 1ns/1ps
interface dctc_tick_if;
  logic div4;
  logic div12;
  logic div48;
  logic ext_div8;

  modport source (output div4, output div12, output div48, output ext_div8);
  modport sink   (input div4, input div12, input div48, input ext_div8);
endinterface

// ---- logic/dctc_prescaler.sv ----
// Purpose: produces the divided system clock enables and the external clock / 8 enable
// Assumes: ext_clock_pin is asynchronous and slower than half the system clock
// Notes:   every enable is a registered one-cycle pulse
`timescale 1ns/1ps
module dctc_prescaler
  import dctc_pkg::*;
#(
  parameter int unsigned DIV_LIST [3] = '{DIV_SHORT, DIV_MID, DIV_LONG},
  parameter int unsigned EXT_RATIO    = DIV_EXT
)
(
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   ext_clock_pin,
  dctc_tick_if.source ticks
);

  logic [2:0]           div_tick;
  logic                 ext_meta;
  logic                 ext_sync;
  logic                 ext_prev;
  logic                 ext_rise;
  logic [EXT_WIDTH-1:0] ext_count;
  logic                 ext_tick;

  // one free-running counter per ratio; separate counters keep each phase simple
  for (genvar i = 0; i < 3; i++)
  begin : g_div
    logic [DIV_WIDTH-1:0] count;
    wire                  wrap = (count == DIV_WIDTH'(DIV_LIST[i] - 1));
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        count       <= '0;
        div_tick[i] <= 1'b0;
      end
      else
      begin
        count       <= wrap ? '0 : count + 1'b1;
        div_tick[i] <= wrap;
      end
    end
  end

  // external clock passes two flops before the edge detector sees it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= ext_clock_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync & ~ext_prev;

  // divide synchronised rising edges by the external ratio
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_count <= '0;
      ext_tick  <= 1'b0;
    end
    else
    begin
      ext_tick <= ext_rise && (ext_count == EXT_WIDTH'(EXT_RATIO - 1));
      if (ext_rise)
        ext_count <= ext_count + 1'b1;
    end
  end

  assign ticks.div4     = div_tick[0];
  assign ticks.div12    = div_tick[1];
  assign ticks.div48    = div_tick[2];
  assign ticks.ext_div8 = ext_tick;

  sequence s_quiet_three;
    !ticks.div4 [*3];
  endsequence

  a_div4_period : assert property (@(posedge clk) disable iff (!nrst)
    ticks.div4 |=> s_quiet_three ##1 ticks.div4)
    else $error("divide by four enable lost its period");

endmodule

// ---- sim/dctc_cpu_model.sv ----
// Purpose: cpu model that reaches the timer registers
// Assumes: strobes are one clock wide, set at falling edges
// Notes:   read data is taken one cycle after the strobe
`timescale 1ns/1ps
module dctc_cpu_model
(
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  // idle bus, both strobes low
  initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
endmodule

// ---- sim/dctc_timer_tb.sv ----
// Purpose: self-checking bench for the dual counter/timer block
// Assumes: cpu model drives the register bus at falling edges
// Notes:   prescaled counts allow one count of divider phase slack
`timescale 1ns/1ps
module dctc_timer_tb
  import dctc_pkg::*;
;
  logic       clk = 1'b0, nrst = 1'b0, pin0 = 1'b1, irq0 = 1'b0, ack0 = 1'b0, wr, rd, flag0;
  logic       pol0 = 1'b1, xclk = 1'b0, xsel = 1'b0;
  wire        flag1, tick1;
  wire  [3:0] tk;
  logic [7:0] addr, wdata, rdata, v, w;
  int         n_mismatch = 0, check_count = 0, cyc = 0, n;
  // 25 ns system clock
  always #12.5 clk = ~clk;
  dctc_cpu_model cpu_u (.clk(clk), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata));
  dctc_timer dut_u (.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .timer_zero_count_pin(pin0),
    .timer_one_count_pin(1'b1), .ext_irq_zero_line(irq0), .ext_irq_one_line(1'b0),
    .ext_irq_zero_polarity(pol0), .ext_irq_one_polarity(1'b0), .ext_clock_pin(xclk),
    .timer_two_extclk_choice(xsel), .timer_three_extclk_choice(xsel),
    .zero_vector_ack(ack0), .one_vector_ack(ack0), .timer_zero_overflow_flag(flag0),
    .timer_one_overflow_flag(flag1), .timer_one_overflow_tick(tick1),
    .timer_two_low_tick(tk[0]), .timer_two_high_tick(tk[1]), .timer_three_low_tick(tk[2]),
    .timer_three_high_tick(tk[3]));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    n_mismatch += (seen !== exp);
    if (seen !== exp)
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
  endtask
  task automatic summarize(input int late = 0);
    n_mismatch += late;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // stop first so the count is loaded while idle; setting run never clears it
  task automatic load_run(input logic [7:0] md, ck, la, lo, ha, hi, run);
    cpu_u.wr(ADDR_RUN_FLAG, 8'h00);
    cpu_u.wr(ADDR_MODE, md);
    cpu_u.wr(ADDR_CLOCK_SEL, ck);
    cpu_u.wr(la, lo);
    cpu_u.wr(ha, hi);
    cpu_u.wr(ADDR_RUN_FLAG, run);
  endtask
  task automatic start0(input logic [7:0] md, ck, lo, hi);
    load_run(md, ck, ADDR_ZERO_LOW, lo, ADDR_ZERO_HIGH, hi, 8'h10);
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{ADDR_MODE, ADDR_ZERO_LOW, ADDR_ONE_LOW, ADDR_ZERO_HIGH, ADDR_CLOCK_SEL};
    foreach (a[i])
    begin
      cpu_u.rd(a[i], v);
      check("reset", v, RESET_BYTE);
      cpu_u.wr(a[i], 8'hA5 ^ a[i]);
      cpu_u.rd(a[i], v);
      check("rw", v, 8'hA5 ^ a[i]);
    end
    cpu_u.rd(8'h80, v);
    check("unmapped", v, 8'h00);
  endtask
  task automatic t_gate;
    start0(8'h09, 8'h04, 8'hFE, 8'hFF);
    repeat (10) @(negedge clk);
    check("gated", {7'h0, flag0}, 8'h00);
    irq0 = 1'b1;
    repeat (10) @(negedge clk);
    check("wrap flag", {7'h0, flag0}, 8'h01);
    ack0 = 1'b1;
    @(negedge clk);
    ack0 = 1'b0;
    check("ack", {7'h0, flag0}, 8'h00);
    // flipping the polarity makes the high line inactive, so the count must freeze
    pol0 = 1'b0;
    cpu_u.rd(ADDR_ZERO_LOW, v);
    cpu_u.rd(ADDR_ZERO_LOW, w);
    check("polarity", w, v);
    pol0 = 1'b1;
  endtask
  task automatic t_pin;
    start0(8'h05, 8'h04, 8'h00, 8'h00);
    repeat (6)
    begin
      repeat (4) @(negedge clk);
      pin0 = ~pin0;
    end
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("pin falls", v, 8'h03);
  endtask
  task automatic t_scale;
    logic [7:0] e [3] = '{8'h08, 8'h18, 8'h02};
    for (int i = 0; i < 3; i++)
    begin
      start0(8'h01, i[7:0], 8'h00, 8'h00);
      repeat (96) @(negedge clk);
      cpu_u.rd(ADDR_ZERO_LOW, v);
      check("prescale", {7'h0, v - e[i] <= 8'h01}, 8'h01);
    end
  endtask
  // sixteen external rising edges give exactly two ext/8 enables
  task automatic t_ext;
    start0(8'h01, 8'h03, 8'h00, 8'h00);
    repeat (32)
    begin
      repeat (2) @(negedge clk);
      xclk = ~xclk;
    end
    repeat (6) @(negedge clk);
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("ext div8", v, 8'h02);
  endtask
  // 13-bit wrap, reload from high, and a write racing an increment
  task automatic t_modes;
    start0(8'h00, 8'h04, 8'hFE, 8'hFF);
    repeat (4) @(negedge clk);
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("13-bit wrap", {7'h0, flag0}, 8'h01);
    check("13-bit top", {5'h0, v[7:5]}, 8'h07);
    start0(8'h02, 8'h04, 8'hFE, 8'h80);
    repeat (4) @(negedge clk);
    cpu_u.rd(ADDR_ZERO_HIGH, v);
    check("reload flag", {7'h0, flag0}, 8'h01);
    check("reload high", v, 8'h80);
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("reload low", {7'h0, v[7]}, 8'h01);
    start0(8'h01, 8'h04, 8'h00, 8'h00);
    cpu_u.wr(ADDR_ZERO_LOW, 8'h55);
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("write wins", v, 8'h56);
  endtask
  // reset in mid-run while timer zero counts
  task automatic t_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("mid reset", v, RESET_BYTE);
  endtask
  // timer one on sysclk, its inactive mode, and the split high byte
  task automatic t_one;
    load_run(8'h10, 8'h08, ADDR_ONE_LOW, 8'hF8, ADDR_ONE_HIGH, 8'hFF, 8'h40);
    n = 0;
    repeat (12)
    begin
      @(negedge clk);
      n += tick1;
    end
    check("one flag", {7'h0, flag1}, 8'h01);
    check("one tick", n[7:0], 8'h01);
    cpu_u.wr(ADDR_MODE, 8'h30);
    cpu_u.rd(ADDR_ONE_LOW, v);
    cpu_u.rd(ADDR_ONE_LOW, w);
    check("one off", w, v);
    load_run(8'h03, 8'h04, ADDR_ZERO_LOW, 8'h00, ADDR_ZERO_HIGH, 8'hF8, 8'h40);
    repeat (12) @(negedge clk);
    cpu_u.rd(ADDR_ZERO_LOW, v);
    check("split flag", {7'h0, flag1}, 8'h01);
    check("split low", v, 8'h00);
  endtask
  // rate enables for the outside timers: sysclk, then /12, then idle ext/8
  task automatic t_ticks;
    cpu_u.wr(ADDR_CLOCK_SEL, 8'hF0);
    @(negedge clk);
    check("sys ticks", {4'h0, tk}, 8'h0F);
    cpu_u.wr(ADDR_CLOCK_SEL, 8'h00);
    n = 0;
    repeat (48)
    begin
      @(negedge clk);
      n += tk[0] + tk[1] + tk[2] + tk[3];
    end
    check("div12 ticks", n[7:0], 8'h10);
    xsel = 1'b1;
    repeat (2) @(negedge clk);
    n = 0;
    repeat (24)
    begin
      @(negedge clk);
      n += tk[0] + tk[1] + tk[2] + tk[3];
    end
    check("ext ticks", n[7:0], 8'h00);
  endtask
  // ceiling well above the roughly 720 cycles the scenarios need
  always @(posedge clk)
    if (++cyc == 3000)
      summarize(1);
  initial
  begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_gate();
    t_pin();
    t_scale();
    t_ext();
    t_modes();
    t_reset();
    t_one();
    t_ticks();
    summarize();
  end
endmodule
